// ===== design/fsr_cfg.svh
// Constants for the flash protection and ECC configuration register slice.
// Assumes an AHB-Lite host; each 8-bit register sits in the low byte of one word.
//
// Summary of operation
// [RL1] Protection state register is fully readable; software writes to it are ignored.
// [RL2] Protection state is loaded from the nonvolatile security byte during reset sequence.
// [RL3] Double-bit fault on the security phrase load sets every protection state bit.
// [RL4] Backdoor key enable field bits 7..6: only code 10 enables key access.
// [RL5] Lock state field bits 1..0: only code 10 means unsecured.
// [RL6] Unsecuring through the backdoor key forces the lock state field to 10.
// [RL7] Software leaves reserved nonvolatile bits 5..2 erased for future use.
// [RL8] Command word index holds bits 2..0 selecting the command object word.
// [RL9] Command word index bits read and write; other bits read zero, ignore writes.
// [RL10] ECC result index selects the ECC fault result word returned on reads.
// [RL11] ECC result index bits read and write; other bits read zero, ignore writes.
// [RL12] Configuration register: only bits 7, 4, 1, 0 are read-write, rest zero.
// [RL13] Command-done interrupt enable requests an interrupt while command complete is set.
// [RL14] Ignore-single-fault suppresses single-bit fault reporting and its interrupt.
// [RL15] Force-double-fault makes every array read set the double-fault flag.
// [RL16] Force-single-fault makes every array read set the single-fault flag; here not while ignore-single is set.
// [RL17] Forced double fault leaves ECC result array alone unless genuinely faulted.
// [RL18] Forced single fault leaves ECC result array alone unless genuinely faulted.
// [RL19] With force bits clear, flags set only on real faults during array reads.
// [RL20] Force bits hold until software writes zero; hardware never clears them.
// [RL21] Command complete flag reads one when finished, zero while a command runs.
// [RL22] Double-fault interrupt enable requests an interrupt while double-fault flag set.
// [RL23] All registers are eight bits wide, reached by byte data at base plus offset.
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH

// -----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------------------
`define FSR_IDX_PROT      5'h01
`define FSR_IDX_CMD       5'h02
`define FSR_IDX_ECC       5'h03
`define FSR_IDX_CFG       5'h04
`define FSR_IDX_ERRCFG    5'h05
`define FSR_IDX_ERRSTAT   5'h06
`define FSR_IDX_STAT      5'h07

// -----------------------------------------------------------------------------
// Field layouts and reset values
// -----------------------------------------------------------------------------
`define FSR_PROT_RESET    8'hFF
`define FSR_PROT_ALL_SET  8'hFF
`define FSR_CODE_ON       2'h2
`define FSR_KEY_HI        7
`define FSR_KEY_LO        6
`define FSR_LOCK_HI       1
`define FSR_LOCK_LO       0
`define FSR_INDEX_RESET   3'h0
`define FSR_CFG_RESET     8'h00
`define FSR_CFG_MASK      8'h93
`define FSR_DONE_IE_BIT   7
`define FSR_IGN_SGL_BIT   4
`define FSR_FORCE_DBL_BIT 1
`define FSR_FORCE_SGL_BIT 0
`define FSR_ERR_MASK      8'h03
`define FSR_DBL_BIT       1
`define FSR_SGL_BIT       0
`define FSR_DONE_BIT      7
`define FSR_FLAG_NONE     2'h0
`define FSR_PAD           24'h000000
`define FSR_BYTE_ZERO     8'h00
`define FSR_HRESP_OKAY    1'h0

`endif

// ===== design/fsr_pkg.sv
// Types shared by the flash protection and ECC configuration register slice.
// Assumes the constants header is included wherever numbers are needed.
`default_nettype none

package fsr_pkg;

    // -------------------------------------------------------------------------
    // Data types
    // -------------------------------------------------------------------------
    typedef logic [7:0]  fsr_byte_t;
    typedef logic [2:0]  fsr_index_t;
    typedef logic [1:0]  fsr_flag_pair_t;
    typedef logic [31:0] fsr_word_t;

    // Bus data-phase tracker
    typedef enum logic [1:0] {
        FSR_PH_IDLE  = 2'b00,
        FSR_PH_WRITE = 2'b01,
        FSR_PH_RWAIT = 2'b10,
        FSR_PH_RDONE = 2'b11
    } fsr_phase_t;

endpackage

`default_nettype wire

// ===== design/fsr_regs.sv
// Flash protection state, command/ECC index and configuration registers.
// Assumes a single AHB-Lite master, and a flash core on the same clock that
// pulses the security load, backdoor unlock and array read strobes.
//
// The AHB-Lite interface to the registers is this design's own decision.
`include "fsr_cfg.svh"
`default_nettype none

module fsr_regs (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output fsr_pkg::fsr_word_t        hrdata,
    input  wire logic                 nvm_load_valid,
    input  wire fsr_pkg::fsr_byte_t   nvm_prot_byte,
    input  wire logic                 nvm_double_fault,
    input  wire logic                 backdoor_unlock,
    input  wire logic                 cmd_idle,
    input  wire logic                 array_read,
    input  wire logic                 ecc_single_detect,
    input  wire logic                 ecc_double_detect,
    output fsr_pkg::fsr_index_t       command_index,
    output fsr_pkg::fsr_index_t       ecc_index,
    output logic                      ecc_result_update,
    output logic                      backdoor_key_enabled,
    output logic                      part_secured,
    output logic                      cmd_done_irq,
    output logic                      double_fault_irq,
    output logic                      single_fault_irq
);
    import fsr_pkg::*;

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    fsr_phase_t     phase;
    fsr_phase_t     next_phase;
    logic [4:0]     addr_idx;
    fsr_byte_t      rd_byte;
    fsr_byte_t      protection_state_reg;
    fsr_index_t     command_word_index;
    fsr_index_t     ecc_result_index;
    fsr_byte_t      flash_config_reg;
    fsr_flag_pair_t irq_enable;
    fsr_flag_pair_t fault_flag;

    // -------------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------------

    // Address phase is taken only when the bus is ready
    wire        accept     = hsel & htrans[1] & hready;
    wire        wr_phase   = (phase == FSR_PH_WRITE);
    wire        rd_wait    = (phase == FSR_PH_RWAIT);
    wire [7:0]  wr_byte    = hwdata[7:0];   // [RL23]

    // Register selects, decoded from the latched word index
    wire        sel_prot    = (addr_idx == `FSR_IDX_PROT);
    wire        sel_cmd     = (addr_idx == `FSR_IDX_CMD);
    wire        sel_ecc     = (addr_idx == `FSR_IDX_ECC);
    wire        sel_cfg     = (addr_idx == `FSR_IDX_CFG);
    wire        sel_errcfg  = (addr_idx == `FSR_IDX_ERRCFG);
    wire        sel_errstat = (addr_idx == `FSR_IDX_ERRSTAT);
    wire        sel_stat    = (addr_idx == `FSR_IDX_STAT);

    // Write strobes; the protection state has none at all
    wire        wr_cmd      = wr_phase & sel_cmd;
    wire        wr_ecc      = wr_phase & sel_ecc;
    wire        wr_cfg      = wr_phase & sel_cfg;
    wire        wr_errcfg   = wr_phase & sel_errcfg;
    wire        wr_errstat  = wr_phase & sel_errstat;

    // -------------------------------------------------------------------------
    // Phase tracking
    // -------------------------------------------------------------------------

    // Reads insert one wait state so that read data always leaves a flop
    always_comb begin
        next_phase = FSR_PH_IDLE;
        case (phase)
            FSR_PH_IDLE,
            FSR_PH_WRITE,
            FSR_PH_RDONE: begin
                if (accept) begin
                    next_phase = hwrite ? FSR_PH_WRITE : FSR_PH_RWAIT;
                end
            end
            FSR_PH_RWAIT: begin
                next_phase = FSR_PH_RDONE;
            end
            default: begin
                next_phase = FSR_PH_IDLE;
            end
        endcase
    end

    // Phase register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= FSR_PH_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    // Word index of the pending transfer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_idx <= 5'h00;
        end else if (accept) begin
            addr_idx <= haddr[6:2];
        end
    end

    assign hreadyout = ~rd_wait;
    assign hresp     = `FSR_HRESP_OKAY;    // Never an error, even if unmapped

    // -------------------------------------------------------------------------
    // Protection state
    // -------------------------------------------------------------------------

    // Held fully set until the load arrives, so the part starts secured.
    // No bus write path exists, which is why writes vanish silently.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            protection_state_reg <= `FSR_PROT_RESET;
        end else if (nvm_load_valid) begin
            if (nvm_double_fault) begin
                protection_state_reg <= `FSR_PROT_ALL_SET;                // [RL3]
            end else begin
                protection_state_reg <= nvm_prot_byte;                    // [RL2] [RL7]
            end
        end else if (backdoor_unlock) begin
            protection_state_reg[`FSR_LOCK_HI:`FSR_LOCK_LO] <= `FSR_CODE_ON;  // [RL6]
        end
    end

    // Decoded security state for the rest of the chip
    assign backdoor_key_enabled =
        (protection_state_reg[`FSR_KEY_HI:`FSR_KEY_LO] == `FSR_CODE_ON);   // [RL4]
    assign part_secured =
        (protection_state_reg[`FSR_LOCK_HI:`FSR_LOCK_LO] != `FSR_CODE_ON); // [RL5]

    // -------------------------------------------------------------------------
    // Index registers
    // -------------------------------------------------------------------------

    // Only the low three bits exist; upper data bits are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            command_word_index <= `FSR_INDEX_RESET;
        end else if (wr_cmd) begin
            command_word_index <= wr_byte[2:0];                           // [RL8] [RL9]
        end
    end

    // Same shape for the ECC result word select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ecc_result_index <= `FSR_INDEX_RESET;
        end else if (wr_ecc) begin
            ecc_result_index <= wr_byte[2:0];                             // [RL10] [RL11]
        end
    end

    assign command_index = command_word_index;
    assign ecc_index     = ecc_result_index;

    // -------------------------------------------------------------------------
    // Configuration
    // -------------------------------------------------------------------------

    // Force bits stay until software writes zero; nothing here clears them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_config_reg <= `FSR_CFG_RESET;
        end else if (wr_cfg) begin
            flash_config_reg <= wr_byte & `FSR_CFG_MASK;                  // [RL12] [RL20]
        end
    end

    wire done_ie   = flash_config_reg[`FSR_DONE_IE_BIT];
    wire ign_sgl   = flash_config_reg[`FSR_IGN_SGL_BIT];
    wire force_dbl = flash_config_reg[`FSR_FORCE_DBL_BIT];
    wire force_sgl = flash_config_reg[`FSR_FORCE_SGL_BIT];

    // Error interrupt enables, bit 1 double and bit 0 single
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_enable <= `FSR_FLAG_NONE;
        end else if (wr_errcfg) begin
            irq_enable <= wr_byte[`FSR_DBL_BIT:`FSR_SGL_BIT];
        end
    end

    // -------------------------------------------------------------------------
    // Fault flags
    // -------------------------------------------------------------------------

    // Fault causes per flag; ignore-single also mutes forced single faults
    wire [1:0] fault_set;
    assign fault_set[`FSR_DBL_BIT] =
        array_read & (force_dbl | ecc_double_detect);                      // [RL15] [RL19]
    assign fault_set[`FSR_SGL_BIT] =
        array_read & ~ign_sgl & (force_sgl | ecc_single_detect);           // [RL14] [RL16] [RL19]

    // Sticky flags, write one to clear; a new fault in the clear cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_flag
            wire clr = wr_errstat & wr_byte[gi];
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    fault_flag[gi] <= 1'h0;
                end else if (fault_set[gi]) begin
                    fault_flag[gi] <= 1'h1;
                end else if (clr) begin
                    fault_flag[gi] <= 1'h0;
                end
            end
        end
    endgenerate

    // Result array only moves on genuine faults, never on forced ones
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ecc_result_update <= 1'b0;
        end else begin
            ecc_result_update <= array_read &
                (ecc_double_detect | ecc_single_detect);                  // [RL17] [RL18]
        end
    end

    // -------------------------------------------------------------------------
    // Interrupt requests (levels)
    // -------------------------------------------------------------------------
    assign cmd_done_irq     = done_ie & cmd_idle;                         // [RL13] [RL21]
    assign double_fault_irq = irq_enable[`FSR_DBL_BIT] & fault_flag[`FSR_DBL_BIT];  // [RL22]
    assign single_fault_irq = irq_enable[`FSR_SGL_BIT] & fault_flag[`FSR_SGL_BIT];  // [RL14]

    // -------------------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------------------

    // Read selection; unmapped words read as zero
    wire [7:0] rd_mux =
        sel_prot    ? protection_state_reg :                              // [RL1]
        sel_cmd     ? {5'h00, command_word_index} :                       // [RL9]
        sel_ecc     ? {5'h00, ecc_result_index} :                         // [RL11]
        sel_cfg     ? flash_config_reg :
        sel_errcfg  ? {6'h00, irq_enable} :
        sel_errstat ? {6'h00, fault_flag} :
        sel_stat    ? {cmd_idle, 7'h00} :                                 // [RL21]
                      `FSR_BYTE_ZERO;

    // Sample in the wait state; held until the next read replaces it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_byte <= `FSR_BYTE_ZERO;
        end else if (rd_wait) begin
            rd_byte <= rd_mux;
        end
    end

    assign hrdata = {`FSR_PAD, rd_byte};                                  // [RL23]

endmodule

`default_nettype wire

// ===== tb/fsr_regs_props.sv
// Checker for the flash protection and ECC configuration register slice.
// Assumes it is bound to fsr_regs and sees only that module's ports.
`include "fsr_cfg.svh"
`default_nettype none

module fsr_regs_props (
    input wire logic               hclk,
    input wire logic               hresetn,
    input wire logic               hsel,
    input wire logic [31:0]        haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic               hready,
    input wire logic               hreadyout,
    input wire logic               nvm_load_valid,
    input wire fsr_pkg::fsr_byte_t nvm_prot_byte,
    input wire logic               nvm_double_fault,
    input wire logic               backdoor_unlock,
    input wire logic               cmd_idle,
    input wire logic               array_read,
    input wire logic               ecc_single_detect,
    input wire logic               ecc_double_detect,
    input wire fsr_pkg::fsr_index_t command_index,
    input wire fsr_pkg::fsr_index_t ecc_index,
    input wire logic               ecc_result_update,
    input wire logic               backdoor_key_enabled,
    input wire logic               part_secured,
    input wire logic               cmd_done_irq,
    input wire logic               double_fault_irq
);
    import fsr_pkg::*;

    // ----------------------------------------------------------------
    // Transfer decode
    // ----------------------------------------------------------------
    wire logic take    = hsel && htrans[1] && hready;
    wire logic rd_take = take && !hwrite;
    wire logic wr_cmd  = take && hwrite && (haddr[6:2] == `FSR_IDX_CMD);
    wire logic wr_ecc  = take && hwrite && (haddr[6:2] == `FSR_IDX_ECC);
    wire logic genuine = ecc_single_detect || ecc_double_detect;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    load_fault_a: assert property (nvm_load_valid && nvm_double_fault |=>
        part_secured && !backdoor_key_enabled) else $error("faulted load left part open");
    load_decode_a: assert property (nvm_load_valid && !nvm_double_fault |=>
        backdoor_key_enabled == ($past(nvm_prot_byte[7:6]) == 2'h2) &&
        part_secured == ($past(nvm_prot_byte[1:0]) != 2'h2)) else $error("security decode wrong");
    unlock_lock_a: assert property (backdoor_unlock && !nvm_load_valid |=> !part_secured)
        else $error("unlock did not open part");
    sec_hold_a: assert property (!nvm_load_valid && !backdoor_unlock |=>
        $stable(part_secured) && $stable(backdoor_key_enabled)) else $error("security changed alone");
    read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    write_wait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    update_cause_a: assert property (ecc_result_update |-> $past(array_read) && $past(genuine))
        else $error("result update without fault");
    update_absent_a: assert property (array_read && !genuine |=> !ecc_result_update)
        else $error("forced fault updated results");
    cmd_irq_gate_a: assert property (cmd_done_irq |-> cmd_idle)
        else $error("done irq while busy");
    cmd_index_a: assert property ($changed(command_index) |-> $past(wr_cmd, 2))
        else $error("command index moved alone");
    ecc_index_a: assert property ($changed(ecc_index) |-> $past(wr_ecc, 2))
        else $error("ecc index moved alone");

    cov_read_c: cover property (rd_take ##2 hreadyout);
    cov_dbl_c: cover property ($rose(double_fault_irq));
    cov_load_c: cover property (nvm_load_valid ##1 !part_secured);
endmodule

bind fsr_regs fsr_regs_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .nvm_load_valid(nvm_load_valid), .nvm_prot_byte(nvm_prot_byte), .nvm_double_fault(nvm_double_fault),
    .backdoor_unlock(backdoor_unlock), .cmd_idle(cmd_idle), .array_read(array_read),
    .ecc_single_detect(ecc_single_detect), .ecc_double_detect(ecc_double_detect),
    .command_index(command_index), .ecc_index(ecc_index), .ecc_result_update(ecc_result_update),
    .backdoor_key_enabled(backdoor_key_enabled), .part_secured(part_secured),
    .cmd_done_irq(cmd_done_irq), .double_fault_irq(double_fault_irq));

`default_nettype wire

// ===== tb/fsr_flash_model.sv
// Flash core stand-in: security load, unlock, idle level and array read strobes.
// Assumes the bench calls its tasks just after a rising edge of hclk.
`default_nettype none

module fsr_flash_model (
    input  wire logic          hclk,
    output fsr_pkg::fsr_byte_t nvm_prot_byte,
    output logic               nvm_load_valid,
    output logic               nvm_double_fault,
    output logic               backdoor_unlock,
    output logic               cmd_idle,
    output logic               array_read,
    output logic               ecc_single_detect,
    output logic               ecc_double_detect
);
    import fsr_pkg::*;

    // Qualified lines carry the inverse outside their strobe, so stale data never passes
    initial begin
        nvm_prot_byte     = 8'hA5;
        nvm_load_valid    = 1'h0;
        nvm_double_fault  = 1'h1;
        backdoor_unlock   = 1'h0;
        cmd_idle          = 1'h1;
        array_read        = 1'h0;
        ecc_single_detect = 1'h1;
        ecc_double_detect = 1'h1;
    end

    // One-cycle security load with its fault qualifier
    task automatic load(input fsr_byte_t b, input logic dbl);
        nvm_load_valid   <= 1'h1;
        nvm_prot_byte    <= b;
        nvm_double_fault <= dbl;
        @(posedge hclk);
        nvm_load_valid   <= 1'h0;
        nvm_prot_byte    <= ~b;
        nvm_double_fault <= ~dbl;
    endtask

    // Backdoor key accepted for one cycle
    task automatic unlock();
        backdoor_unlock <= 1'h1;
        @(posedge hclk);
        backdoor_unlock <= 1'h0;
    endtask

    // Command engine level: 1 when finished
    task automatic idle(input logic v);
        cmd_idle <= v;
        @(posedge hclk);
    endtask

    // One array read with its genuine fault results
    task automatic rd(input logic s, input logic d);
        array_read        <= 1'h1;
        ecc_single_detect <= s;
        ecc_double_detect <= d;
        @(posedge hclk);
        array_read        <= 1'h0;
        ecc_single_detect <= ~s;
        ecc_double_detect <= ~d;
    endtask
endmodule

`default_nettype wire

// ===== tb/fsr_regs_tb_top.sv
// Self-checking bench for the flash protection and ECC configuration registers.
// Assumes fsr_regs, its header on the include path, the flash model and the checker.
`default_nettype none

module fsr_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fsr_pkg::*;

    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    fsr_word_t hwdata, hrdata;
    fsr_byte_t nvm_prot_byte;
    fsr_index_t command_index, ecc_index;
    logic nvm_load_valid, nvm_double_fault, backdoor_unlock, cmd_idle, array_read;
    logic ecc_single_detect, ecc_double_detect, ecc_result_update, backdoor_key_enabled;
    logic part_secured, cmd_done_irq, double_fault_irq, single_fault_irq;
    int fails, check_count;
    fsr_byte_t q[$];
    logic rd_pend = 1'h0;

    fsr_regs dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .nvm_load_valid, .nvm_prot_byte,
        .nvm_double_fault, .backdoor_unlock, .cmd_idle, .array_read, .ecc_single_detect,
        .ecc_double_detect, .command_index, .ecc_index, .ecc_result_update,
        .backdoor_key_enabled, .part_secured, .cmd_done_irq, .double_fault_irq, .single_fault_irq);
    fsr_flash_model fm (.hclk, .nvm_prot_byte, .nvm_load_valid, .nvm_double_fault,
        .backdoor_unlock, .cmd_idle, .array_read, .ecc_single_detect, .ecc_double_detect);

    initial begin
        hclk = 1'h0;
        forever #20 hclk = ~hclk;
    end

    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask

    task automatic report_and_stop();
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Bounded wait for hready; a hung slave ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'h1 && n < 20);
        if (hreadyout !== 1'h1) begin
            fails++;
            report_and_stop();
        end
    endtask

    // Single word transfer; for a read, d is the expected byte
    task automatic bus(input logic w, input logic [7:0] a, input fsr_byte_t d);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        if (!w) q.push_back(d);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
    endtask

    // Array read, then irq and update outputs once the edge has landed
    task automatic fault(input logic s, input logic d, input logic [2:0] e);
        fm.rd(s, d);
        #1;
        chk("single_fault_irq", e[0], single_fault_irq);
        chk("double_fault_irq", e[1], double_fault_irq);
        chk("ecc_result_update", e[2], ecc_result_update);
        @(posedge hclk);
    endtask

    // Read monitor: each finished read data phase takes the oldest note
    always @(posedge hclk) begin
        if (rd_pend && hreadyout === 1'h1) begin
            rd_pend = 1'h0;
            chk("hrdata", {24'h0, q.pop_front()}, hrdata);
            chk("hresp", 32'h0, hresp);
        end
        if (hsel && htrans[1] && hreadyout && !hwrite) rd_pend = 1'h1;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        fsr_byte_t r;
        void'($urandom(32'h6A41EFF3));
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        bus(0, 8'h04, 8'hFF);
        bus(0, 8'h0C, 8'h00);
        for (int i = 0; i < 3; i++) begin
            r = 8'($urandom);
            bus(1, 8'h08, r);
            bus(1, 8'h0C, ~r);
            bus(1, 8'h10, r);
            bus(1, 8'h04, r);
            bus(1, 8'h20, r);
            bus(0, 8'h08, r & 8'h07);
            bus(0, 8'h0C, ~r & 8'h07);
            bus(0, 8'h10, r & 8'h93);
            bus(0, 8'h04, 8'hFF);
            bus(0, 8'h20, 8'h00);
            chk("command_index", r[2:0], command_index);
            chk("ecc_index", {29'h0, ~r[2:0]}, ecc_index);
        end
        for (int i = 0; i < 4; i++) begin
            r = {i[1:0], 4'hF, i[1:0]};    // reserved bits erased
            fm.load(r, 1'h0);
            #1;
            chk("backdoor_key_enabled", i == 2, backdoor_key_enabled);
            chk("part_secured", i != 2, part_secured);
            @(posedge hclk);
            bus(0, 8'h04, r);
        end
        fm.unlock();
        bus(0, 8'h04, 8'hFE);
        fm.load(8'h82, 1'h1);
        bus(0, 8'h04, 8'hFF);
        bus(1, 8'h10, 8'h80);
        fm.idle(1'h0);
        chk("cmd_done_irq", 0, cmd_done_irq);
        bus(0, 8'h1C, 8'h00);
        fm.idle(1'h1);
        chk("cmd_done_irq", 1, cmd_done_irq);
        bus(0, 8'h1C, 8'h80);
        bus(1, 8'h14, 8'h03);
        bus(1, 8'h10, 8'h02);
        fault(0, 0, 3'h2);
        fault(0, 1, 3'h6);
        bus(0, 8'h18, 8'h02);
        bus(0, 8'h10, 8'h02);
        bus(1, 8'h18, 8'h03);
        bus(1, 8'h10, 8'h11);
        fault(0, 0, 3'h0);
        bus(1, 8'h10, 8'h01);
        fault(0, 0, 3'h1);
        bus(1, 8'h18, 8'h03);
        bus(1, 8'h10, 8'h00);
        fault(0, 0, 3'h0);
        fault(1, 0, 3'h5);
        bus(0, 8'h18, 8'h01);
        report_and_stop();
    end
endmodule

`default_nettype wire
